//--- hdl/done_sync_pkg.sv
/*
  Shared constants and types for the system done-line synchroniser.
  Assumes a single core clock domain and a synchronous active-high reset.
*/
package done_sync_pkg;

  // Synchroniser depth for the asynchronous done-sense pin
  localparam int unsigned SYNC_STAGES      = 2;
  // Reset value of the release drive (high holds the shared line low)
  localparam logic        RELEASE_RST_VAL  = 1'b1;
  // Reset value of the synchroniser flops (line assumed low: not all done)
  localparam logic        SENSE_RST_VAL    = 1'b0;
  // Consecutive high samples needed before the system is declared ready
  localparam int unsigned READY_FILTER_DEF = 4;
  // Index given to the chain device nearest the module's test-data output
  localparam logic [3:0]  CHAIN_FIRST_IDX  = 4'h0;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_HOLD    = 4'b0001,  // Line held low, waiting for configuration done
    ST_INIT    = 4'b0010,  // Local initialisation running, still holding
    ST_WAIT    = 4'b0100,  // Released, polling the shared line
    ST_RUN     = 4'b1000   // Whole system configured
  } seq_state_t;

  // Status bundle presented to user logic
  typedef struct packed {
    logic released;        // Own hold on the shared line has been dropped
    logic system_ready;    // Every participant has released the line
  } done_status_t;

endpackage : done_sync_pkg

//--- hdl/done_sense_sync.sv
/*
  Two-flop synchroniser for the shared done-sense pin.
  Assumes the pin is asynchronous to core_clk; the output is safe to use
  in the core domain.
*/
module done_sense_sync
  import done_sync_pkg::*;
(
  input  wire logic core_clk,  // Core clock
  input  wire logic rst,       // Synchronous reset, active high
  input  wire logic clk_en,    // Freezes the flops while low
  input  wire logic async_in,  // Raw pin level
  output logic      sync_out   // Level in the core domain
);

  ////////////////////////////////////////////////////////////////////////
  logic [SYNC_STAGES-1:0] stage_r;    // Synchroniser chain
  logic [SYNC_STAGES-1:0] stage_nxt;  // Next chain value

  // Shift the pin in; only the next stage reads the first flop
  always_comb begin
    stage_nxt = stage_r;
    if (clk_en) begin
      stage_nxt = {stage_r[SYNC_STAGES-2:0], async_in};
    end
  end

  // Register the chain
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stage_r <= {SYNC_STAGES{SENSE_RST_VAL}};
    end else begin
      stage_r <= stage_nxt;
    end
  end

  assign sync_out = stage_r[SYNC_STAGES-1];

endmodule // done_sense_sync

//--- hdl/config_done_sync.sv
/*
  Configuration-completion synchroniser for one FPGA on a multi-FPGA
  module. Drives the module release output and senses the wired-AND
  system done line. Assumes the carrier holds the line up weakly and the
  module's transistor pulls it low while release_drive_output is high.
*/
module config_done_sync
  import done_sync_pkg::*;
#(
  parameter int unsigned READY_FILTER = READY_FILTER_DEF  // High samples needed
) (
  input  wire logic  core_clk,             // Core clock, 20 MHz
  input  wire logic  rst,                  // Synchronous reset, active high
  input  wire logic  clk_en,               // Freezes all state while low
  input  wire logic  config_complete,      // Local configuration finished
  input  wire logic  init_required,        // Hold release until init done
  input  wire logic  init_done,            // Local initialisation finished
  input  wire logic  done_sense_input,     // Shared done line, asynchronous
  output logic       release_drive_output, // High keeps the line pulled low
  output logic       init_start,           // Request to run initialisation
  output done_status_t status              // Release and system-ready flags
);

  ////////////////////////////////////////////////////////////////////////
  // Synchronised view of the shared line
  logic sense_sync;  // Shared line level in core domain

  done_sense_sync u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .async_in (done_sense_input),
    .sync_out (sense_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer state
  localparam int unsigned CW = $clog2(READY_FILTER + 1);
  localparam logic [CW-1:0] FILT_MAX = CW'(READY_FILTER);

  seq_state_t      state_r, state_nxt;  // Sequencer
  logic [CW-1:0]   filt_r, filt_nxt;    // Count of consecutive high samples
  logic            rel_r, rel_nxt;      // Release drive register
  logic            start_r, start_nxt;  // Init request register
  done_status_t    stat_r, stat_nxt;    // Status register

  // Next-state logic; the filter rejects short glitches on a slow wired line
  always_comb begin
    state_nxt = state_r;
    filt_nxt  = filt_r;
    rel_nxt   = rel_r;
    start_nxt = start_r;
    stat_nxt  = stat_r;
    if (clk_en) begin
      case (state_r)
        ST_HOLD: begin
          rel_nxt = 1'b1;
          if (config_complete && init_required) begin
            state_nxt = ST_INIT;
            start_nxt = 1'b1;
          end else if (config_complete) begin
            state_nxt = ST_WAIT;
            rel_nxt   = 1'b0;
          end
        end
        ST_INIT: begin
          if (init_done) begin
            state_nxt = ST_WAIT;
            start_nxt = 1'b0;
            rel_nxt   = 1'b0;
          end
        end
        ST_WAIT: begin
          // Any low sample restarts the count: someone still holds it
          if (!sense_sync) begin
            filt_nxt = '0;
          end else if (filt_r == FILT_MAX - 1'b1) begin
            filt_nxt  = FILT_MAX;
            state_nxt = ST_RUN;
          end else begin
            filt_nxt = filt_r + 1'b1;
          end
        end
        ST_RUN: begin
          // Line dropped again: a peer was reconfigured, stop and poll
          if (!sense_sync) begin
            state_nxt = ST_WAIT;
            filt_nxt  = '0;
          end
        end
        default: begin
          state_nxt = ST_HOLD;
          rel_nxt   = 1'b1;
        end
      endcase
      // Losing local configuration always re-asserts the hold
      if (!config_complete) begin
        state_nxt = ST_HOLD;
        rel_nxt   = 1'b1;
        start_nxt = 1'b0;
        filt_nxt  = '0;
      end
      stat_nxt.released     = !rel_nxt;
      stat_nxt.system_ready = (state_nxt == ST_RUN);
    end
  end

  // Register all sequencer state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= ST_HOLD;
      filt_r  <= '0;
      rel_r   <= RELEASE_RST_VAL;
      start_r <= 1'b0;
      stat_r  <= '0;
    end else begin
      state_r <= state_nxt;
      filt_r  <= filt_nxt;
      rel_r   <= rel_nxt;
      start_r <= start_nxt;
      stat_r  <= stat_nxt;
    end
  end

  // Release output only switches the external pull-down, never drives high
  assign release_drive_output = rel_r;
  assign init_start           = start_r;
  assign status               = stat_r;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  // Checks that expect a transition are gated by clk_en: a frozen cycle
  // would otherwise look like a missed step of the sequencer.

  // An unconfigured module keeps its hold on the shared line
  a_hold_unconfig: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && !config_complete |=> release_drive_output)
    else $error("release dropped while unconfigured");

  // Plain configuration lets go of the line on the next enabled edge
  a_release_after: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && state_r == ST_HOLD && config_complete && !init_required)
    |=> !release_drive_output)
    else $error("release not dropped after configuration");

  // No release while the local initialisation is still running
  a_init_delays: assert property (@(posedge core_clk) disable iff (rst)
    (state_r == ST_INIT) |-> release_drive_output)
    else $error("released during initialisation");

  // End of initialisation lets go of the line and ends the request
  a_init_release: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && state_r == ST_INIT && init_done && config_complete)
    |=> !release_drive_output && !init_start)
    else $error("release not dropped after initialisation");

  // Ready only follows a high synchronised sample while released
  a_ready_needs_high: assert property (@(posedge core_clk) disable iff (rst)
    $rose(status.system_ready) |-> $past(sense_sync) && !release_drive_output)
    else $error("ready without high sense");

  // A low synchronised line withdraws ready on the next enabled edge
  a_low_clears_ready: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && !sense_sync && config_complete) |=> !status.system_ready)
    else $error("ready while line low");

  // Ready only after the full run of consecutive high samples
  a_ready_filter: assert property (@(posedge core_clk) disable iff (rst)
    $rose(status.system_ready) |-> filt_r == FILT_MAX)
    else $error("ready before filter count");

  // Ready is reported only from the run state, with the line released
  a_ready_in_run: assert property (@(posedge core_clk) disable iff (rst)
    status.system_ready |-> (state_r == ST_RUN) && !release_drive_output)
    else $error("ready outside run state");

  // Flag and drive never disagree, in either direction
  a_released_flag: assert property (@(posedge core_clk) disable iff (rst)
    status.released == !release_drive_output)
    else $error("released flag disagrees with drive");

  // Losing configuration drops the init request and ready together
  a_unconfig_idle: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && !config_complete |=> !init_start && !status.system_ready)
    else $error("init or ready left up while unconfigured");

  // Two enabled edges carry the pin level to the sequencer, no more
  a_sync_delay: assert property (@(posedge core_clk) disable iff (rst)
    clk_en [*2] |=> sense_sync == $past(done_sense_input, 2))
    else $error("sense not delayed by two flops");

  // A low enable freezes every register of the sequencer
  a_enable_freeze: assert property (@(posedge core_clk) disable iff (rst)
    !clk_en |=> $stable(state_r) && $stable(filt_r) && $stable(release_drive_output)
      && $stable(init_start) && $stable(status))
    else $error("state moved while clock enable low");

  // Sequencer code stays one-hot
  a_state_onehot: assert property (@(posedge core_clk) disable iff (rst)
    $onehot(state_r))
    else $error("sequencer state not one-hot");

  // Main scenarios: direct release, init path, peer drop, loss, stall
  c_direct_run: cover property (@(posedge core_clk) disable iff (rst)
    state_r == ST_HOLD ##[1:20] state_r == ST_RUN);
  c_init_path: cover property (@(posedge core_clk) disable iff (rst)
    state_r == ST_INIT ##[1:40] status.system_ready);
  c_peer_drop: cover property (@(posedge core_clk) disable iff (rst)
    state_r == ST_RUN ##1 state_r == ST_WAIT);
  c_unconfig_drop: cover property (@(posedge core_clk) disable iff (rst)
    status.system_ready ##1 !config_complete);
  c_stall_wait: cover property (@(posedge core_clk) disable iff (rst)
    state_r == ST_WAIT && !clk_en);

endmodule // config_done_sync

//--- tb/peer_fpgas.sv
/* Model of the other participants on the shared done line.
   Assumes the carrier pull-up lifts the line when nobody holds it. */
module peer_fpgas #(
  parameter int N = 3                  // Other participants
) (
  input  wire logic [N-1:0] peer_hold, // High: that peer pulls low
  input  wire logic         dut_hold,  // The block's own pull-down
  output logic              done_line  // Resolved wired-AND level
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pull-down only, never driven high; the pull-up wins when all let go
  assign done_line = !(dut_hold || |peer_hold);
endmodule // peer_fpgas

//--- tb/testbench.sv
/* Self-checking bench for config_done_sync beside the peer model.
   Assumes a 20 MHz core clock and synchronous active-high reset. */
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("wrong value at %0t: %b vs %b", $time, a, b); end end
module testbench
  import done_sync_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FILT = 2;             // Shortened ready filter
  logic         core_clk, rst, clk_en, cfg, init_req, init_dn;
  logic         sense, rel, init_st;
  logic [2:0]   peer_hold;             // Peers still unconfigured
  done_status_t st;
  logic [3:0]   exp_q[$];              // Expected output changes
  logic [3:0]   last_v = 'x;           // Last output vector seen
  logic [3:0]   exp_v;                 // Oldest note, popped once per result
  int           errors = 0, checked = 0;
  wire  [3:0]   out_v = {rel, init_st, st};

  config_done_sync #(.READY_FILTER(FILT)) i_dut (.core_clk(core_clk), .rst(rst),
    .clk_en(clk_en), .config_complete(cfg), .init_required(init_req),
    .init_done(init_dn), .done_sense_input(sense), .release_drive_output(rel),
    .init_start(init_st), .status(st));
  peer_fpgas #(.N(3)) i_peer (.peer_hold(peer_hold), .dut_hold(rel), .done_line(sense));

  initial begin
    core_clk = 0;
    forever #25 core_clk = ~core_clk;
  end
  // Every output change is one result, matched to the oldest note; the note
  // is popped once, ahead of the compare, so a mismatch cannot eat another
  always @(negedge core_clk) begin
    if (out_v !== last_v) begin
      last_v = out_v;
      exp_v  = exp_q.size() ? exp_q.pop_front() : ~out_v;
      `CHK(out_v, exp_v)
    end
  end
  //////////////////////////////////////////////////////////////////
  task automatic tick(input int n);    // Land just after an edge
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic settle();             // Bounded wait for all notes
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 60) begin
      tick(1);
      n++;
    end
    if (exp_q.size() != 0) begin
      errors++;
      $display("wrong value at %0t: result missing", $time);
      exp_q.delete();
    end
  endtask
  task automatic summarize();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #200us;
    errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    summarize();
  end
  initial begin
    void'($urandom(32'hb05c29e3));
    {rst, cfg, init_req, init_dn} = 4'b1000;
    clk_en    = 1'b1;
    peer_hold = 3'b111;
    // Random stalls only shift timing; the queue checks order and values.
    // Forked after the seed so the stall pattern follows it.
    fork
      forever begin
        @(posedge core_clk);
        #1;
        clk_en = rst || ($urandom % 4 != 0);
      end
    join_none
    exp_q.push_back(4'b1000);          // Reset: holding, nothing ready
    tick(4);
    rst = 0;
    settle();
    `CHK(sense, 1'b0)
    `CHK(CHAIN_FIRST_IDX, 4'h0)
    // Random init and peer inputs while unconfigured change nothing
    repeat (12) begin
      {init_req, init_dn, peer_hold} = 5'($urandom);
      tick(1);
      `CHK(sense, 1'b0)
    end
    {init_req, init_dn} = 2'b00;
    peer_hold = 3'b111;
    tick(1);
    cfg = 1;
    exp_q.push_back(4'b0010);
    settle();
    tick(20);
    // Peers let go one by one; ready only after the last
    for (int i = 0; i < 3; i++) begin
      if (i == 2) exp_q.push_back(4'b0011);
      peer_hold[i] = 0;
      tick(20);
    end
    settle();
    peer_hold[1] = 1;                  // Peer reconfigures
    exp_q.push_back(4'b0010);
    settle();
    peer_hold[1] = 0;
    exp_q.push_back(4'b0011);
    settle();
    rst = 1;                           // Reset in mid-run drops everything
    exp_q.push_back(4'b1000);
    tick(2);
    rst = 0;
    exp_q.push_back(4'b0010);          // Still configured: release at once
    exp_q.push_back(4'b0011);          // Filter refills from a cleared chain
    settle();
    cfg = 0;                           // Loss of configuration
    exp_q.push_back(4'b1000);
    settle();
    tick(3);
    `CHK(sense, 1'b0)
    // Initialisation delays the release
    {cfg, init_req} = 2'b11;
    exp_q.push_back(4'b1100);
    settle();
    tick($urandom_range(8, 1));
    `CHK(sense, 1'b0)
    init_dn = 1;
    exp_q.push_back(4'b0010);
    exp_q.push_back(4'b0011);
    settle();
    init_dn = 0;
    `CHK(sense, 1'b1)
    summarize();
  end
endmodule // testbench
